// ===== inc/crs_pkg.sv
package crs_pkg;

  // stream geometry
  localparam int DATA_W = 512;
  localparam int BYTES = 64;
  localparam int USER_W = 100;
  localparam int START_W = 12;
  localparam int FLAG_W = 4;
  localparam int OFFSET_W = 4;

  // sideband field positions
  localparam int START_LSB = 0;
  localparam int END_FLAGS_LSB = 12;
  localparam int ABORT_LSB = 16;
  localparam int END_OFFSET_FIRST_LSB = 20;
  localparam int END_OFFSET_SECOND_LSB = 24;
  localparam int END_OFFSET_THIRD_LSB = 28;
  localparam int END_OFFSET_FOURTH_LSB = 32;
  localparam int PARITY_LSB = 36;

  // end flags and first end offset written into a beat cut short by an abort
  localparam logic [3:0] END_FLAGS_ONE = 4'h1;
  localparam logic [3:0] LAST_DWORD = 4'hF;

  // credit counter
  localparam int CREDIT_W = 8;
  localparam logic [7:0] CREDIT_MAX = 8'hFF;
  localparam logic [7:0] CREDIT_RESET = 8'h00;

  // hold stage
  localparam logic [1:0] HOLD_DEPTH = 2'h2;

  // register port
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] MASK_OFFSET = 8'h08;
  localparam logic [7:0] CREDIT_OFFSET = 8'h0C;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_TRUNCATE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int STAT_ABORT_BIT = 0;
  localparam int STAT_PAUSE_BIT = 1;
  localparam int STAT_OVERFLOW_BIT = 2;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  typedef struct packed {
    logic [511:0] data;
    logic [11:0] start_fields;
    logic [3:0] end_flags;
    logic [3:0] end_offset_first;
    logic [3:0] end_offset_second;
    logic [3:0] end_offset_third;
    logic [3:0] end_offset_fourth;
    logic [3:0] abort;
  } crs_beat_type;

endpackage

// ===== inc/crs_parity_if.sv
`timescale 1ns/100ps

interface crs_parity_if;
  logic [511:0] data;
  logic [63:0] parity;

  modport gen (
    input data,
    output parity
  );

  modport user (
    output data,
    input parity
  );
endinterface

// ===== rtl/crs_parity_gen.sv
`timescale 1ns/100ps

module crs_parity_gen (
  // data in, parity out
  crs_parity_if.gen bus
);

  // odd parity: the byte plus its bit holds an odd number of ones
  function automatic logic odd_parity(input logic [7:0] value);
    odd_parity = ~(^value);
  endfunction

  genvar i;
  generate
    for (i = 0; i < crs_pkg::BYTES; i = i + 1) begin : g_byte
      assign bus.parity[i] = odd_parity(bus.data[8*i +: 8]); // RL10
    end
  endgenerate

endmodule

// ===== rtl/crs_rx_framer.sv
`timescale 1ns/100ps

// How it works
// (RL1) abort field bits 19:16 flags errored packet
// (RL2) abort may appear in any beat
// (RL3) abort either truncates packet or continues
// (RL4) abort only while stream valid high
// (RL5) user nullifies aborted packet on link
// (RL6) bits 23:20 first ending offset
// (RL7) bits 27:24 second ending offset
// (RL8) bits 31:28 third ending offset
// (RL9) bits 35:32 fourth ending offset
// (RL10) bits 99:36 odd parity per byte
// (RL11) user may nullify on parity mismatch
// (RL12) present beats only while credits available
// (RL13) no credit mid packet drops valid
// (RL14) resume one cycle after credit return
// (RL15) user transmit valid may drop mid packet
// (RL16) user may gather credits before transmitting
// (RL17) end flags set only in final beat
// (RL18) credit count up on return, down on use
module crs_rx_framer (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // beats from the core datapath
  input wire logic src_valid,
  input wire logic [511:0] src_data,
  input wire logic [11:0] src_start_fields,
  input wire logic [3:0] src_packet_end_flags,
  input wire logic [3:0] src_end_offset_first,
  input wire logic [3:0] src_end_offset_second,
  input wire logic [3:0] src_end_offset_third,
  input wire logic [3:0] src_end_offset_fourth,
  input wire logic [3:0] src_abort,
  output logic src_ready,
  // credit return from user logic
  input wire logic credit_return,
  // receive stream to user logic
  output logic rx_valid,
  output logic [511:0] rx_data,
  output logic [99:0] rx_user,
  // interrupt
  output logic irq
);

  // hold stage: two entries so that a registered ready keeps full rate
  crs_pkg::crs_beat_type hold_mem [0:1];
  logic [1:0] occ_reg;
  logic [1:0] occ_next;
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic src_ready_reg;

  // presentation state
  logic [7:0] credit_reg;
  logic [7:0] credit_next;
  logic drop_reg;
  logic drop_next;
  logic in_tlp_reg;
  logic in_tlp_next;
  logic rx_valid_reg;
  logic [511:0] rx_data_reg;
  logic [99:0] rx_user_reg;
  logic [99:0] user_next;

  // registers
  logic [1:0] ctrl_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] mask_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic irq_reg;

  // decode of the head entry
  crs_pkg::crs_beat_type head;
  crs_pkg::crs_beat_type incoming;
  wire head_valid;
  wire head_ends;
  wire head_aborts;
  wire enable;
  wire truncate_mode;
  wire credit_avail;
  wire credit_accept;
  wire take;
  wire present;
  wire drop;
  wire pop;
  wire trunc;
  wire abort_evt;
  wire pause_evt;
  wire overflow_evt;
  wire [2:0] events;
  wire rd_status;
  wire wr_ctrl;
  wire wr_mask;
  wire [3:0] end_flags_out;
  wire [3:0] offset_first_out;

  // a flag field counts as raised when any of its bits is set
  function automatic logic any_set(input logic [3:0] flags);
    any_set = flags != 4'h0;
  endfunction

  // parity of the beat about to be presented
  crs_parity_if par_bus ();

  crs_parity_gen u_parity (
    .bus(par_bus)
  );

  assign incoming.data = src_data;
  assign incoming.start_fields = src_start_fields;
  assign incoming.end_flags = src_packet_end_flags;
  assign incoming.end_offset_first = src_end_offset_first;
  assign incoming.end_offset_second = src_end_offset_second;
  assign incoming.end_offset_third = src_end_offset_third;
  assign incoming.end_offset_fourth = src_end_offset_fourth;
  assign incoming.abort = src_abort;

  assign head = hold_mem[rd_ptr_reg];
  assign head_valid = occ_reg != 2'h0;
  assign head_ends = any_set(head.end_flags);
  assign head_aborts = any_set(head.abort);
  assign par_bus.data = head.data;

  assign enable = ctrl_reg[crs_pkg::CTRL_ENABLE_BIT];
  assign truncate_mode = ctrl_reg[crs_pkg::CTRL_TRUNCATE_BIT];

  // a credit returned this cycle may be spent this cycle, so a paused
  // beat reappears in the very next cycle
  assign credit_avail = (credit_reg != 8'h00) || credit_return; // RL14
  // a return at the ceiling is refused and flagged rather than wrapping the count
  assign credit_accept = credit_return && (credit_reg != crs_pkg::CREDIT_MAX);

  assign take = src_valid && src_ready_reg;
  assign present = head_valid && !drop_reg && enable && credit_avail; // RL12
  // beats left of a truncated packet are discarded without credit
  assign drop = head_valid && drop_reg;
  assign pop = present || drop;
  assign trunc = present && truncate_mode && head_aborts && !head_ends; // RL3

  assign occ_next = occ_reg + {1'b0, take} - {1'b0, pop};

  // one credit per presented beat
  assign credit_next = credit_reg + {7'h00, credit_accept} - {7'h00, present}; // RL18

  assign drop_next = trunc ? 1'b1 : ((drop && head_ends) ? 1'b0 : drop_reg);
  assign in_tlp_next = present ? !(head_ends || trunc) : in_tlp_reg;

  // events for the status register
  assign abort_evt = present && head_aborts;
  // raised in every cycle stalled mid packet for lack of credit, so a stall that outlasts a read is seen again
  assign pause_evt = in_tlp_reg && head_valid && !drop_reg && enable && !credit_avail; // RL13
  assign overflow_evt = credit_return && (credit_reg == crs_pkg::CREDIT_MAX);
  assign events = {overflow_evt, pause_evt, abort_evt};

  // a truncated beat closes the packet at its last dword
  assign end_flags_out = trunc ? crs_pkg::END_FLAGS_ONE : head.end_flags; // RL17
  assign offset_first_out = trunc ? crs_pkg::LAST_DWORD : head.end_offset_first;

  always_comb begin
    user_next = '0;
    user_next[crs_pkg::START_LSB +: crs_pkg::START_W] = head.start_fields;
    user_next[crs_pkg::END_FLAGS_LSB +: crs_pkg::FLAG_W] = end_flags_out; // RL17
    user_next[crs_pkg::ABORT_LSB +: crs_pkg::FLAG_W] = head.abort; // RL1 RL2
    user_next[crs_pkg::END_OFFSET_FIRST_LSB +: crs_pkg::OFFSET_W] = offset_first_out; // RL6
    user_next[crs_pkg::END_OFFSET_SECOND_LSB +: crs_pkg::OFFSET_W] = head.end_offset_second; // RL7
    user_next[crs_pkg::END_OFFSET_THIRD_LSB +: crs_pkg::OFFSET_W] = head.end_offset_third; // RL8
    user_next[crs_pkg::END_OFFSET_FOURTH_LSB +: crs_pkg::OFFSET_W] = head.end_offset_fourth; // RL9
    // parity is taken from the head entry, the same data that leaves with it
    user_next[crs_pkg::PARITY_LSB +: crs_pkg::BYTES] = par_bus.parity; // RL10
    if (!present) begin
      // idle cycles never carry abort or end flags
      user_next = rx_user_reg;
      user_next[crs_pkg::ABORT_LSB +: crs_pkg::FLAG_W] = 4'h0; // RL4
      user_next[crs_pkg::END_FLAGS_LSB +: crs_pkg::FLAG_W] = 4'h0; // RL17
    end
  end

  // register decode
  assign rd_status = reg_read && (reg_addr == crs_pkg::STATUS_OFFSET);
  assign wr_ctrl = reg_write && (reg_addr == crs_pkg::CTRL_OFFSET);
  assign wr_mask = reg_write && (reg_addr == crs_pkg::MASK_OFFSET);

  // an event in the clearing read's cycle survives the clear
  assign status_next = (rd_status ? 3'h0 : status_reg) | events;

  // unmapped addresses and idle cycles answer with zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_read) begin
      case (reg_addr)
        crs_pkg::CTRL_OFFSET: rdata_next = {30'h0000_0000, ctrl_reg};
        crs_pkg::STATUS_OFFSET: rdata_next = {29'h0000_0000, status_reg};
        crs_pkg::MASK_OFFSET: rdata_next = {29'h0000_0000, mask_reg};
        crs_pkg::CREDIT_OFFSET: rdata_next = {24'h00_0000, credit_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // hold stage; entries carry no reset since occupancy guards them
  always_ff @(posedge clock) begin
    if (take) begin
      hold_mem[wr_ptr_reg] <= incoming;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      occ_reg <= 2'h0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
    end else begin
      occ_reg <= occ_next;
      wr_ptr_reg <= wr_ptr_reg ^ take;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
    end
  end

  // at most one beat enters next cycle, so one free slot suffices
  always_ff @(posedge clock) begin
    if (reset) begin
      src_ready_reg <= 1'b0;
    end else begin
      src_ready_reg <= occ_next < crs_pkg::HOLD_DEPTH;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      credit_reg <= crs_pkg::CREDIT_RESET;
      drop_reg <= 1'b0;
      in_tlp_reg <= 1'b0;
    end else begin
      credit_reg <= credit_next; // RL18
      drop_reg <= drop_next; // RL3
      in_tlp_reg <= in_tlp_next;
    end
  end

  // a presented beat and its sideband leave on the same edge
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_valid_reg <= 1'b0;
      rx_user_reg <= '0;
    end else begin
      rx_valid_reg <= present; // RL12 RL13
      rx_user_reg <= user_next;
    end
  end

  // data holds between beats, so a paused stream shows no motion
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_data_reg <= '0;
    end else if (present) begin
      rx_data_reg <= head.data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_reg <= crs_pkg::CTRL_RESET;
      mask_reg <= crs_pkg::MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata[1:0];
      end
      if (wr_mask) begin
        mask_reg <= reg_wdata[2:0];
      end
    end
  end

  // the clear and the irq drop land on the edge of the status read
  always_ff @(posedge clock) begin
    if (reset) begin
      status_reg <= crs_pkg::STATUS_RESET;
      rdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      rdata_reg <= rdata_next;
      irq_reg <= (status_next & mask_reg) != 3'h0;
    end
  end

  assign src_ready = src_ready_reg;
  assign rx_valid = rx_valid_reg;
  assign rx_data = rx_data_reg;
  assign rx_user = rx_user_reg;
  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;

endmodule

// ===== bench/crs_rx_framer_chk.sv
`timescale 1ns/100ps
module crs_rx_framer_chk (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // watched ports
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic src_ready,
  input wire logic credit_return,
  input wire logic rx_valid,
  input wire logic [511:0] rx_data,
  input wire logic [99:0] rx_user
);
  logic [63:0] par_exp;
  logic [8:0] cnt_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  always_comb begin
    for (int i = 0; i < 64; i++) par_exp[i] = ~^rx_data[8*i +: 8];
  end
  // own tally, so a lost or doubled credit inside the design still shows
  always_ff @(posedge clock) begin
    if (reset) cnt_reg <= 9'h000;
    else cnt_reg <= cnt_reg + {8'h00, credit_return} - {8'h00, rx_valid};
  end
  abort_needs_valid_a: assert property (!rx_valid |-> rx_user[19:16] == 4'h0)
    else $error("abort flags without valid");
  end_flags_idle_a: assert property (!rx_valid |-> rx_user[15:12] == 4'h0)
    else $error("end flags without valid");
  parity_odd_a: assert property (rx_valid |-> rx_user[99:36] == par_exp)
    else $error("byte parity not odd");
  credit_gate_a: assert property (rx_valid |-> cnt_reg != 9'h000)
    else $error("beat presented without credit");
  resume_next_a: assert property ((credit_return && cnt_reg == 9'h000 && !src_ready
    && $past(!src_ready)) |=> rx_valid) else $error("no resume after credit");
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  data_hold_a: assert property ($changed(rx_data) |-> rx_valid)
    else $error("data moved while paused");
  offsets_hold_a: assert property (!rx_valid |-> $stable(rx_user[35:20]))
    else $error("offsets moved while idle");
  cover property (rx_valid && rx_user[19:16] != 4'h0);
  cover property (rx_valid && rx_user[15:12] == 4'hF);
  cover property (credit_return && !src_ready ##1 rx_valid);
  cover property (rx_valid && rx_user[19:16] != 4'h0 && rx_user[15:12] == 4'h1);
endmodule

bind crs_rx_framer crs_rx_framer_chk u_crs_rx_framer_chk (
  .clock(clock), .reset(reset), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .src_ready(src_ready), .credit_return(credit_return), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_user(rx_user)
);

// ===== bench/crs_user_model.sv
`timescale 1ns/100ps
module crs_user_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // pacing from the bench
  input wire logic credit_en,
  input wire logic [1:0] gap,
  // receive stream
  input wire logic rx_valid,
  input wire logic [511:0] rx_data,
  input wire logic [99:0] rx_user,
  // credits and tallies
  output logic credit_return,
  output logic [7:0] null_count,
  output logic [7:0] perr_count
);
  logic [1:0] tick_reg;
  logic [63:0] par_ok;
  always_comb begin
    for (int i = 0; i < 64; i++) par_ok[i] = ^{rx_data[8*i +: 8], rx_user[36+i]};
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      tick_reg <= 2'h0;
      credit_return <= 1'b0;
      null_count <= 8'h00;
      perr_count <= 8'h00;
    end else begin
      tick_reg <= (tick_reg >= gap) ? 2'h0 : tick_reg + 2'h1;
      credit_return <= credit_en && tick_reg == 2'h0;
      // each aborted beat would be nullified on the link
      if (rx_valid && rx_user[19:16] != 4'h0) null_count <= null_count + 8'h01;
      if (rx_valid && par_ok != {64{1'b1}}) perr_count <= perr_count + 8'h01;
    end
  end
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic src_valid = 1'b0;
  logic credit_en = 1'b0;
  logic rd_pend = 1'b0;
  logic [1:0] gap = 2'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  crs_pkg::crs_beat_type beat = '0;
  logic src_ready, credit_return, rx_valid, irq;
  logic [31:0] reg_rdata;
  logic [511:0] rx_data;
  logic [99:0] rx_user;
  logic [7:0] null_count, perr_count;
  logic [547:0] beat_q[$];
  logic [31:0] reg_q[$];
  logic [547:0] trunc_exp;
  int err_count = 0;
  int samples_checked = 0;
  always #4 clock = ~clock;
  crs_rx_framer u_crs_rx_framer (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .src_valid(src_valid), .src_data(beat.data), .src_start_fields(beat.start_fields),
    .src_packet_end_flags(beat.end_flags), .src_end_offset_first(beat.end_offset_first),
    .src_end_offset_second(beat.end_offset_second),
    .src_end_offset_third(beat.end_offset_third),
    .src_end_offset_fourth(beat.end_offset_fourth), .src_abort(beat.abort),
    .src_ready(src_ready), .credit_return(credit_return), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_user(rx_user), .irq(irq)
  );
  crs_user_model u_crs_user_model (
    .clock(clock), .reset(reset), .credit_en(credit_en), .gap(gap), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_user(rx_user), .credit_return(credit_return),
    .null_count(null_count), .perr_count(perr_count)
  );
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [547:0] got, input logic [547:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h", $time, what, got);
    end
  endtask
  task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= wr;
    reg_read <= !wr;
    if (!wr) reg_q.push_back(v);
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    @(posedge clock);
  endtask
  // leaves src_valid high so beats can follow back to back
  task automatic send(input logic [3:0] fl, input logic [3:0] ab);
    crs_pkg::crs_beat_type b;
    int n;
    for (int i = 0; i < 16; i++) b.data[32*i +: 32] = $urandom;
    b.start_fields = 12'($urandom);
    {b.end_offset_first, b.end_offset_second, b.end_offset_third,
      b.end_offset_fourth} = 16'($urandom);
    b.end_flags = fl;
    b.abort = ab;
    beat <= b;
    src_valid <= 1'b1;
    beat_q.push_back({b.data, b.end_offset_fourth, b.end_offset_third,
      b.end_offset_second, b.end_offset_first, ab, fl, b.start_fields});
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (src_ready !== 1'b1 && n < 300);
    if (n >= 300) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (beat_q.size() != 0 && n < 300) begin
      @(posedge clock);
      n++;
    end
    if (n >= 300) begin
      err_count++;
      wrap_up();
    end
  endtask
  always @(negedge clock) begin
    if (rd_pend) chk(reg_rdata, reg_q.pop_front(), "reg");
    rd_pend = reg_read;
    if (rx_valid === 1'b1) chk({rx_data, rx_user[35:0]}, beat_q.pop_front(), "beat");
  end
  initial begin
    void'($urandom(59));
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    reg_acc(1'b0, 8'h00, 32'h0000_0001);
    reg_acc(1'b0, 8'h08, 32'h0000_0000);
    reg_acc(1'b1, 8'h10, 32'hFFFF_FFFF);
    reg_acc(1'b0, 8'h10, 32'h0000_0000);
    reg_acc(1'b0, 8'h0C, 32'h0000_0000);
    $display("test registers done");
    send(4'h0, 4'h0);
    send(4'h0, 4'h0);
    src_valid <= 1'b0;
    repeat (3) @(posedge clock);
    chk(rx_valid, 1'b0, "no credit");
    credit_en <= 1'b1;
    @(posedge clock);
    credit_en <= 1'b0;
    repeat (4) @(posedge clock);
    reg_acc(1'b0, 8'h04, 32'h0000_0002);
    send(4'h1, 4'h0);
    src_valid <= 1'b0;
    gap <= 2'h1;
    credit_en <= 1'b1;
    repeat (8) @(posedge clock);
    credit_en <= 1'b0;
    drain();
    reg_acc(1'b0, 8'h0C, 32'h0000_0002);
    reg_acc(1'b0, 8'h04, 32'h0000_0002);
    $display("test credits done");
    gap <= 2'h0;
    credit_en <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      send(4'h0, 4'h0);
      send(4'hF >> (3 - k), 4'h0);
    end
    send(4'h0, 4'h2);
    send(4'h1, 4'h0);
    src_valid <= 1'b0;
    drain();
    reg_acc(1'b1, 8'h00, 32'h0000_0003);
    send(4'h0, 4'h0);
    send(4'h0, 4'h1);
    trunc_exp = beat_q.pop_back();
    trunc_exp[15:12] = crs_pkg::END_FLAGS_ONE;
    trunc_exp[23:20] = crs_pkg::LAST_DWORD;
    beat_q.push_back(trunc_exp);
    send(4'h0, 4'h0);
    void'(beat_q.pop_back());
    send(4'h3, 4'h0);
    void'(beat_q.pop_back());
    send(4'h1, 4'h0);
    src_valid <= 1'b0;
    drain();
    $display("test truncate done");
    reg_acc(1'b1, 8'h00, 32'h0000_0000);
    send(4'h1, 4'h0);
    src_valid <= 1'b0;
    repeat (3) @(posedge clock);
    chk(rx_valid, 1'b0, "disabled");
    reg_acc(1'b1, 8'h00, 32'h0000_0001);
    drain();
    credit_en <= 1'b0;
    repeat (2) @(posedge clock);
    chk(irq, 1'b0, "masked irq");
    reg_acc(1'b1, 8'h08, 32'h0000_0001);
    @(posedge clock);
    chk(irq, 1'b1, "irq raised");
    reg_acc(1'b0, 8'h04, 32'h0000_0001);
    @(posedge clock);
    chk(irq, 1'b0, "irq cleared");
    chk(null_count, 8'h02, "nullified");
    chk(perr_count, 8'h00, "parity");
    $display("test stream done");
    wrap_up();
  end
endmodule
